// [hw/eisa_pkg.sv]
// constants, timing counts and state type for the serial memory slave front end
package eisa_pkg;
    localparam int CLK_MHZ = 200;

    // input noise suppression, least stable width in ns, rounded up to cycles
    localparam int FILT_STD_NS = 100;
    localparam int FILT_FAST_NS = 50;
    localparam logic [4:0] FILT_STD_CYC = 5'((FILT_STD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] FILT_FAST_CYC = 5'((FILT_FAST_NS * CLK_MHZ + 999) / 1000);

    // self-timed write cycle, longest time in ms, rounded down to cycles
    localparam int WR_STD_MS = 10;
    localparam int WR_LOW_MS = 15;
    localparam int WR_STD_CYC = WR_STD_MS * CLK_MHZ * 1000;
    localparam int WR_LOW_CYC = WR_LOW_MS * CLK_MHZ * 1000;
    localparam int WR_CNT_W = 22;

    // device type identifier; value is arbitrary
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;

    // bit counter positions within a nine-clock byte frame
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST_TX = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;

    // reset values
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [9:0] ADDR_RST = 10'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_DATA,
        ST_READ,
        ST_IGNORE
    } eisa_state_t;
endpackage

// [hw/eisa_glitch_filter.sv]
// two-flop synchroniser followed by a stable-width pulse filter
module eisa_glitch_filter (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // line in, minimum width in cycles, filtered line out
    input  wire logic       line_raw,
    input  wire logic [4:0] len,
    output logic            line_clean
);
    logic       s1_q;
    logic       s2_q;
    logic       dout_q;
    logic [4:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= eisa_pkg::LINE_IDLE;
            s2_q <= eisa_pkg::LINE_IDLE;
        end else begin
            s1_q <= line_raw;
            s2_q <= s1_q;
        end
    end

    // a new level must hold len cycles before it passes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 5'h00;
            dout_q <= eisa_pkg::LINE_IDLE;
        end else if (s2_q == dout_q) begin
            cnt_q <= 5'h00;
        end else if (cnt_q >= 5'(len - 5'h01)) begin
            dout_q <= s2_q;
            cnt_q  <= 5'h00;
        end else begin
            cnt_q <= 5'(cnt_q + 5'h01);
        end
    end

    assign line_clean = dout_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_filter_width:
    assert property ($changed(dout_q) |-> $past(cnt_q) == 5'($past(len) - 5'h01))
        else $error("filtered line changed before minimum width");

    a_filter_level:
    assert property ($changed(dout_q) |-> $past(s2_q) == dout_q && $past(s2_q, 2) == dout_q)
        else $error("filtered line took a level that was not stable");
endmodule

// [hw/eisa_slave.sv]
// two-wire slave front end: addressing, acknowledge, array address, busy lockout
// Behaviour
// - write cycle starts at stop, bounded time
// - busy: release data line, never acknowledge
// - reject line pulses narrower than filter width
// - addressed receiver acknowledges every received byte
// - write: slave receives; read: master acknowledges
// - slave address: type, selection, direction bit
// - respond only when device type matches
// - selection bits must match select inputs
// - spare selection bits choose 256-byte block
// - direction bit one reads, zero writes
// - transmitter releases data after eight bits
// - acknowledge low in ninth clock, then release
// - array address picks byte within block
// - write page is 16 aligned bytes
// - data changes with clock low; start/stop
// - top selection bit against single select pin
// - read: continue on acknowledge, else wait stop
module eisa_slave #(
    parameter int         WR_CYCLES = eisa_pkg::WR_STD_CYC,
    parameter logic [3:0] DEV_TYPE  = eisa_pkg::DEV_TYPE_DEFAULT
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // bus pins, data is open drain
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    output logic            sda_level,
    output logic            sda_oe,
    // straps
    input  wire logic       chip_select_pin_high,
    input  wire logic       fast_mode,
    // memory array port
    output logic [9:0]      mem_addr,
    output logic [7:0]      mem_wdata,
    output logic            mem_we,
    input  wire logic [7:0] mem_rdata,
    // status
    output logic            busy
);
    logic                          rst_meta_q;
    logic                          rst_n;
    logic                          cs_meta_q;
    logic                          cs_q;
    logic                          fm_meta_q;
    logic                          fm_q;
    logic                          scl_f;
    logic                          sda_f;
    logic                          scl_p_q;
    logic                          sda_p_q;
    logic                          scl_rise;
    logic                          scl_fall;
    logic                          start_c;
    logic                          stop_c;
    logic                          dev_match;
    logic [4:0]                    filt_len;
    eisa_pkg::eisa_state_t         state_q;
    logic [3:0]                    cnt_q;
    logic [7:0]                    sr_q;
    logic [7:0]                    tx_q;
    logic                          rw_q;
    logic                          mack_q;
    logic                          wrote_q;
    logic                          sda_o_q;
    logic                          sda_oe_q;
    logic [9:0]                    mem_addr_q;
    logic [7:0]                    mem_wdata_q;
    logic                          mem_we_q;
    logic                          busy_q;
    logic [eisa_pkg::WR_CNT_W-1:0] busy_cnt_q;
    logic [eisa_pkg::WR_CNT_W-1:0] busy_len_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // straps are static but still come from pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_meta_q <= 1'b0;
            cs_q      <= 1'b0;
            fm_meta_q <= 1'b0;
            fm_q      <= 1'b0;
        end else begin
            cs_meta_q <= chip_select_pin_high;
            cs_q      <= cs_meta_q;
            fm_meta_q <= fast_mode;
            fm_q      <= fm_meta_q;
        end
    end

    assign filt_len = fm_q ? eisa_pkg::FILT_FAST_CYC : eisa_pkg::FILT_STD_CYC;

    eisa_glitch_filter u_scl_filt (
        .clk        (clk),
        .rst_n      (rst_n),
        .line_raw   (scl_pin),
        .len        (filt_len),
        .line_clean (scl_f)
    );

    eisa_glitch_filter u_sda_filt (
        .clk        (clk),
        .rst_n      (rst_n),
        .line_raw   (sda_pin),
        .len        (filt_len),
        .line_clean (sda_f)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q <= eisa_pkg::LINE_IDLE;
            sda_p_q <= eisa_pkg::LINE_IDLE;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // both lines share one filter delay, so their order is kept
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_c  = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_c   = scl_f & scl_p_q & ~sda_p_q & sda_f;
    // slave address fields: type, select pin bit, two block bits, direction
    assign dev_match = (sr_q[7:4] == DEV_TYPE) && (sr_q[3] == cs_q);

    // write cycle timer; the array is assumed to finish inside it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= '0;
        end else if (stop_c && wrote_q && !busy_q) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= eisa_pkg::WR_CNT_W'(WR_CYCLES - 1);
        end else if (busy_q) begin
            if (busy_cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                busy_cnt_q <= eisa_pkg::WR_CNT_W'(busy_cnt_q - 1'b1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= eisa_pkg::ST_IDLE;
            cnt_q       <= eisa_pkg::BIT_FIRST;
            sr_q        <= eisa_pkg::BYTE_RST;
            tx_q        <= eisa_pkg::BYTE_RST;
            rw_q        <= 1'b0;
            mack_q      <= 1'b0;
            wrote_q     <= 1'b0;
            sda_oe_q    <= 1'b0;
            mem_addr_q  <= eisa_pkg::ADDR_RST;
            mem_wdata_q <= eisa_pkg::BYTE_RST;
            mem_we_q    <= 1'b0;
        end else begin
            mem_we_q <= 1'b0;
            if (busy_q) begin
                state_q  <= eisa_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
                // a stray stop after the write cycle must not relaunch it
                wrote_q  <= 1'b0;
            end else if (start_c) begin
                state_q  <= eisa_pkg::ST_DEV;
                cnt_q    <= eisa_pkg::BIT_FIRST;
                sda_oe_q <= 1'b0;
                wrote_q  <= 1'b0;
            end else if (stop_c) begin
                state_q  <= eisa_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                // page write rolls over inside its 16-byte page
                if (mem_we_q) begin
                    mem_addr_q[3:0] <= 4'(mem_addr_q[3:0] + 4'h1);
                end
                if (scl_rise && state_q != eisa_pkg::ST_IDLE
                        && state_q != eisa_pkg::ST_IGNORE && cnt_q < eisa_pkg::BIT_END) begin
                    cnt_q <= 4'(cnt_q + 4'h1);
                    if (cnt_q < eisa_pkg::BIT_ACK) begin
                        sr_q <= {sr_q[6:0], sda_f};
                    end
                    if (state_q == eisa_pkg::ST_READ && cnt_q == eisa_pkg::BIT_ACK) begin
                        mack_q <= ~sda_f;
                    end
                end
                if (scl_fall) begin
                    case (state_q)
                        eisa_pkg::ST_DEV, eisa_pkg::ST_WORD, eisa_pkg::ST_DATA: begin
                            if (cnt_q == eisa_pkg::BIT_ACK) begin
                                if (state_q == eisa_pkg::ST_DEV) begin
                                    if (dev_match) begin
                                        sda_oe_q         <= 1'b1;
                                        rw_q             <= sr_q[0];
                                        mem_addr_q[9:8]  <= sr_q[2:1];
                                    end else begin
                                        state_q <= eisa_pkg::ST_IGNORE;
                                    end
                                end else if (state_q == eisa_pkg::ST_WORD) begin
                                    sda_oe_q        <= 1'b1;
                                    mem_addr_q[7:0] <= sr_q;
                                end else begin
                                    sda_oe_q    <= 1'b1;
                                    mem_wdata_q <= sr_q;
                                    mem_we_q    <= 1'b1;
                                    wrote_q     <= 1'b1;
                                end
                            end else if (cnt_q == eisa_pkg::BIT_END) begin
                                cnt_q    <= eisa_pkg::BIT_FIRST;
                                sda_oe_q <= 1'b0;
                                if (state_q == eisa_pkg::ST_DEV && rw_q) begin
                                    state_q         <= eisa_pkg::ST_READ;
                                    tx_q            <= mem_rdata;
                                    sda_oe_q        <= ~mem_rdata[7];
                                    mem_addr_q[7:0] <= 8'(mem_addr_q[7:0] + 8'h01);
                                end else if (state_q == eisa_pkg::ST_DEV) begin
                                    state_q <= eisa_pkg::ST_WORD;
                                end else begin
                                    state_q <= eisa_pkg::ST_DATA;
                                end
                            end
                        end
                        eisa_pkg::ST_READ: begin
                            if (cnt_q >= 4'h1 && cnt_q <= eisa_pkg::BIT_LAST_TX) begin
                                tx_q     <= {tx_q[6:0], 1'b0};
                                sda_oe_q <= ~tx_q[6];
                            end else if (cnt_q == eisa_pkg::BIT_ACK) begin
                                sda_oe_q <= 1'b0;
                            end else if (cnt_q == eisa_pkg::BIT_END) begin
                                if (mack_q) begin
                                    cnt_q           <= eisa_pkg::BIT_FIRST;
                                    tx_q            <= mem_rdata;
                                    sda_oe_q        <= ~mem_rdata[7];
                                    mem_addr_q[7:0] <= 8'(mem_addr_q[7:0] + 8'h01);
                                end else begin
                                    state_q  <= eisa_pkg::ST_IGNORE;
                                    sda_oe_q <= 1'b0;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // the pin only ever pulls low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    assign sda_level = sda_o_q;
    assign sda_oe    = sda_oe_q;
    assign mem_addr  = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_we    = mem_we_q;
    assign busy      = busy_q;

    // helper: length of the busy window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_len_q <= '0;
        end else if (busy_q) begin
            busy_len_q <= eisa_pkg::WR_CNT_W'(busy_len_q + 1'b1);
        end else begin
            busy_len_q <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_addr_byte;
        state_q == eisa_pkg::ST_DEV && scl_fall && cnt_q == eisa_pkg::BIT_ACK;
    endsequence

    sequence s_rx_end;
        (state_q == eisa_pkg::ST_WORD || state_q == eisa_pkg::ST_DATA)
            && scl_fall && cnt_q == eisa_pkg::BIT_END;
    endsequence

    a_write_start:
    assert property (stop_c && wrote_q && !busy_q |=> busy_q && !sda_oe_q)
        else $error("write cycle did not start at stop");
    a_write_length:
    assert property ($fell(busy_q) |-> $past(busy_len_q) == eisa_pkg::WR_CNT_W'(WR_CYCLES - 1))
        else $error("write cycle length wrong");
    a_busy_quiet:
    assert property (busy_q |=> !sda_oe_q && state_q == eisa_pkg::ST_IDLE)
        else $error("bus answered during write cycle");
    a_ack_on_match:
    assert property (s_addr_byte ##0 dev_match |=> sda_oe_q)
        else $error("matching address not acknowledged");
    a_type_mismatch:
    assert property (s_addr_byte ##0 (sr_q[7:4] != DEV_TYPE)
                     |=> !sda_oe_q && state_q == eisa_pkg::ST_IGNORE)
        else $error("foreign device type acknowledged");
    a_sel_mismatch:
    assert property (s_addr_byte ##0 (sr_q[3] != cs_q) |=> !sda_oe_q)
        else $error("select pin mismatch acknowledged");
    a_block_select:
    assert property (s_addr_byte ##0 dev_match |=> mem_addr_q[9:8] == $past(sr_q[2:1]))
        else $error("page block not taken from address");
    a_word_address:
    assert property (state_q == eisa_pkg::ST_WORD && scl_fall && cnt_q == eisa_pkg::BIT_ACK
                     |=> mem_addr_q[7:0] == $past(sr_q))
        else $error("array address not taken");
    a_ack_release:
    assert property (s_rx_end |=> !sda_oe_q ##1 !sda_oe_q)
        else $error("acknowledge not released after ninth clock");
    a_drive_low_scl:
    assert property ($rose(sda_oe_q) |-> !scl_f)
        else $error("data line pulled while clock high");
    a_page_wrap:
    assert property (mem_we_q |=> mem_addr_q[9:4] == $past(mem_addr_q[9:4])
                     && mem_addr_q[3:0] == 4'($past(mem_addr_q[3:0]) + 4'h1))
        else $error("page write address left its page");
    a_read_dir:
    assert property (state_q == eisa_pkg::ST_DEV && scl_fall && cnt_q == eisa_pkg::BIT_END
                     |=> state_q == ($past(rw_q) ? eisa_pkg::ST_READ : eisa_pkg::ST_WORD))
        else $error("direction bit not honoured");
    a_read_nack:
    assert property (state_q == eisa_pkg::ST_READ && scl_fall && cnt_q == eisa_pkg::BIT_END
                     && !mack_q |=> state_q == eisa_pkg::ST_IGNORE && !sda_oe_q)
        else $error("read continued without acknowledge");
endmodule

// [test/eisa_bus_master.sv]
// behavioural two-wire bus master that drives the slave's clock and data pins
module eisa_bus_master #(
    parameter int HALF = 40,
    parameter int GLITCH = 8
) (
    // clock
    input  wire logic clk,
    // resolved data wire
    input  wire logic sda,
    // driven pins, data as open drain pull-down enable
    output logic      scl,
    output logic      sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // clock stands high between frames, data released
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // data moves while the clock is low, except at the start and stop edges, which are made with it high
    task automatic start_cond();
        step(1);
        sda_oe <= 1'b0;
        step(HALF / 2);
        scl <= 1'b1;
        step(HALF);
        sda_oe <= 1'b1;
        step(HALF);
        scl <= 1'b0;
        step(HALF / 2);
    endtask

    task automatic stop_cond();
        sda_oe <= 1'b1;
        step(HALF / 2);
        scl <= 1'b1;
        step(HALF);
        sda_oe <= 1'b0;
        step(HALF);
    endtask

    // glitch is a clock pulse shorter than the slave's filter, inside a low phase
    task automatic clock_bit(input logic b, input logic glitch, output logic seen);
        sda_oe <= ~b;
        step(HALF / 2 - GLITCH);
        if (glitch) begin
            scl <= 1'b1;
        end
        step(GLITCH);
        scl <= 1'b0;
        step(GLITCH);
        scl <= 1'b1;
        step(HALF / 2);
        seen = sda;
        step(HALF / 2);
        scl <= 1'b0;
        step(HALF / 2);
    endtask

    // address then array address are sent as whole bytes, msb first
    task automatic wbyte(input logic [7:0] d, input logic glitch, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], glitch && i == 3, s);
        end
        clock_bit(1'b1, 1'b0, s);
        ack = ~s;
    endtask

    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, 1'b0, d[i]);
        end
        clock_bit(~ack, 1'b0, s);
    endtask
endmodule

// [test/eisa_slave_test.sv]
// self-checking bench for the two-wire memory slave front end
module eisa_slave_test;
    timeunit 1ns;
    timeprecision 100ps;

    // bus clock phases are kept long enough to pass the slave's input filter
    localparam int         WR = 2000;
    localparam logic [3:0] DT = eisa_pkg::DEV_TYPE_DEFAULT;

    logic        clk;
    logic        nrst;
    logic        scl;
    logic        sda;
    logic        sda_m_oe;
    logic        sda_o;
    logic        sda_oe;
    logic        strap;
    logic        fast;
    logic [9:0]  mem_addr;
    logic [7:0]  mem_wdata;
    logic        mem_we;
    logic [7:0]  mem_rdata;
    logic        busy;
    logic [17:0] wq[$];
    logic        ack;
    logic [7:0]  rd;
    int          num_errors;
    int          compares;
    int          busy_run;
    int          busy_last;

    // open-drain wire with pull-up
    assign sda = ~(sda_m_oe | (sda_oe & ~sda_o));
    assign mem_rdata = mem_addr[7:0] ^ 8'h5A;

    eisa_slave #(.WR_CYCLES(WR), .DEV_TYPE(DT)) i_eisa_slave (
        .clk(clk), .nrst(nrst), .scl_pin(scl), .sda_pin(sda), .sda_level(sda_o),
        .sda_oe(sda_oe), .chip_select_pin_high(strap), .fast_mode(fast),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .mem_rdata(mem_rdata), .busy(busy)
    );

    eisa_bus_master i_master (.clk(clk), .sda(sda), .scl(scl), .sda_oe(sda_m_oe));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            wq.push_back({mem_addr, mem_wdata});
        end
        if (busy === 1'b1) begin
            busy_run++;
        end else if (busy_run != 0) begin
            busy_last = busy_run;
            busy_run = 0;
        end
    end

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d of %0d compares", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // page write that wraps inside its 16-byte page, then a lockout probe
    task automatic t_write();
        wq.delete();
        i_master.start_cond();
        i_master.wbyte({DT, 1'b1, 2'b10, 1'b0}, 1'b0, ack);
        check("addr ack", ack, 1'b1);
        i_master.wbyte(8'h3E, 1'b0, ack);
        check("word ack", ack, 1'b1);
        for (int i = 1; i <= 3; i++) begin
            i_master.wbyte(8'(i * 17), 1'b0, ack);
            check("data ack", ack, 1'b1);
        end
        i_master.stop_cond();
        check("wr count", 18'(wq.size()), 18'd3);
        check("wr 0", wq[0], {10'h23E, 8'h11});
        check("wr 1", wq[1], {10'h23F, 8'h22});
        check("wr 2", wq[2], {10'h230, 8'h33});
        i_master.start_cond();
        i_master.wbyte({DT, 1'b1, 2'b10, 1'b0}, 1'b0, ack);
        check("busy nack", ack, 1'b0);
        check("busy level", busy, 1'b1);
        i_master.stop_cond();
        wait_idle();
        @(posedge clk);
        check("busy length", 18'(busy_last), 18'(WR));
        check("no wr busy", 18'(wq.size()), 18'd3);
    endtask

    // wrong type, wrong select strap: never acknowledged, no writes
    task automatic t_mismatch();
        logic [7:0] bad[2];
        bad[0] = {DT ^ 4'h3, 1'b1, 2'b00, 1'b0};
        bad[1] = {DT, 1'b0, 2'b00, 1'b0};
        wq.delete();
        for (int i = 0; i < 2; i++) begin
            i_master.start_cond();
            i_master.wbyte(bad[i], 1'b0, ack);
            check("mismatch nack", ack, 1'b0);
            i_master.wbyte(8'h00, 1'b0, ack);
            check("ignored byte", ack, 1'b0);
            i_master.stop_cond();
        end
        // strap low: only a zero selection bit is answered now
        strap <= 1'b0;
        i_master.start_cond();
        i_master.wbyte({DT, 1'b0, 2'b00, 1'b0}, 1'b0, ack);
        check("strap low ack", ack, 1'b1);
        i_master.stop_cond();
        strap <= 1'b1;
        check("no wr mismatch", 18'(wq.size()), 18'd0);
        check("no busy", busy, 1'b0);
    endtask

    // set pointer, repeated start, read wrapping at a block edge, nack, then released
    task automatic t_read();
        wq.delete();
        i_master.start_cond();
        i_master.wbyte({DT, 1'b1, 2'b01, 1'b0}, 1'b0, ack);
        i_master.wbyte(8'hFE, 1'b0, ack);
        check("ptr ack", ack, 1'b1);
        i_master.start_cond();
        i_master.wbyte({DT, 1'b1, 2'b01, 1'b1}, 1'b0, ack);
        check("read ack", ack, 1'b1);
        i_master.rbyte(1'b1, rd);
        check("rd FE", rd, 8'hFE ^ 8'h5A);
        i_master.rbyte(1'b1, rd);
        check("rd FF", rd, 8'hFF ^ 8'h5A);
        i_master.rbyte(1'b0, rd);
        check("rd 00", rd, 8'h00 ^ 8'h5A);
        i_master.rbyte(1'b0, rd);
        check("released", rd, 8'hFF);
        i_master.stop_cond();
        check("rd ptr", mem_addr, 10'h101);
        check("rd no wr", 18'(wq.size()), 18'd0);
        check("rd no busy", busy, 1'b0);
    endtask

    // short clock pulses inside every byte must not add bits
    task automatic t_glitch();
        wq.delete();
        i_master.start_cond();
        i_master.wbyte({DT, 1'b1, 2'b00, 1'b0}, 1'b1, ack);
        check("gl addr ack", ack, 1'b1);
        i_master.wbyte(8'h05, 1'b1, ack);
        i_master.wbyte(8'hC3, 1'b1, ack);
        check("gl data ack", ack, 1'b1);
        i_master.stop_cond();
        check("gl wr", wq[0], {10'h005, 8'hC3});
        wait_idle();
    endtask

    initial begin
        nrst = 1'b0;
        strap = 1'b1;
        fast = 1'b0;
        num_errors = 0;
        compares = 0;
        busy_run = 0;
        busy_last = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (40) @(posedge clk);
        check("reset busy", busy, 1'b0);
        check("reset oe", sda_oe, 1'b0);
        t_write();
        t_mismatch();
        t_read();
        t_glitch();
        // narrower filter: the same short pulses must still be rejected
        fast <= 1'b1;
        t_glitch();
        tally_and_finish();
    end

    // hang guard
    initial begin
        repeat (95000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule
